// ---- logic/pwr_bus_if.sv ----
// wishbone request/answer between the top and its register file
// assumes the top drives clocking for both ends
`timescale 1ns/10ps
interface pwr_bus_if;
  logic [7:0] adr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic we;
  logic [3:0] sel;
  logic req;
  logic ack;
  modport master (output adr, output wdat, output we, output sel, output req, input rdat, input ack);
  modport slave (input adr, input wdat, input we, input sel, input req, output rdat, output ack);
endinterface

// ---- logic/pwr_ctrl.sv ----
// power-down mode controller: sleep, software and hardware standby
// assumes a classic wishbone master and core/pin inputs synchronous to clk
// assumes the clock generator, cpu and port drivers obey the mode outputs
// assumes the transfer controller holds its count steady while done is high
//
// Behaviour
// - sleep instruction, select clear: enter sleep
// - sleep keeps clock and modules running
// - software modes entered only from execution
// - software standby stops clock, resets modules
// - standby pin low forces hardware standby
// - hardware standby: halt, init, ports floating
// - leave hardware standby via pin then reset
// - software standby exits: nmi, reset, pin
// - select bit seven picks sleep or standby
// - select cannot set while watchdog runs
// - sleep wakes on interrupt, reset, pin
// - interrupt wakes into cpu or transfer
// - after transfer run, service only if count zero
// - masked-level interrupts stay pending
// - disabled module interrupts never wake
// - reset pin low in sleep: reset
// - standby pin low in sleep: hardware standby
//
// Decided for this implementation: the Wishbone interface to the registers and the address map.
`timescale 1ns/10ps
module pwr_ctrl
  import pwr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic sleep_exec,
  input wire logic reset_pin_n,
  input wire logic standby_pin_n,
  input wire logic nmi_req,
  input wire logic [7:0] irq_req,
  input wire logic [7:0] irq_en,
  input wire logic [7:0] irq_xfer,
  input wire logic xfer_done,
  input wire logic [15:0] transfer_count_reg,
  output logic clk_run,
  output logic cpu_run,
  output logic cpu_regs_lost,
  output logic modules_run,
  output logic modules_init,
  output logic ports_hiz,
  output logic irq_service,
  output logic xfer_start,
  output logic cpu_reset
);
  pwr_bus_if bus ();
  pwr_state_e state_reg;
  pwr_state_e state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic clr_sel;
  logic sel_bit;
  logic wdt_run;
  logic wake;
  logic wake_xfer;
  logic [LEVEL_W-1:0] mask_level;
  logic svc_reg;
  logic svc_next;
  logic xs_reg;
  logic xs_next;
  logic lost_reg;
  logic lost_next;
  logic [7:0] status;

  assign bus.adr = wb_adr_i;
  assign bus.wdat = wb_dat_i;
  assign bus.we = wb_we_i;
  assign bus.sel = wb_sel_i;
  assign bus.req = wb_cyc_i && wb_stb_i;
  assign wb_dat_o = bus.rdat;
  assign wb_ack_o = bus.ack;

  pwr_regs u_regs (
    .clk(clk),
    .rst(rst),
    .bus(bus),
    .status_in(status),
    .clr_sel(clr_sel),
    .sel_bit(sel_bit),
    .wdt_run(wdt_run),
    .mask_level(mask_level)
  );

  pwr_wake u_wake (
    .irq_req(irq_req),
    .irq_en(irq_en),
    .irq_xfer(irq_xfer),
    .mask_level(mask_level),
    .wake(wake),
    .wake_xfer(wake_xfer)
  );

  // status: regs-lost flag above the state code
  assign status = {4'h0, lost_reg, 3'(state_reg)};

  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    clr_sel = 1'b0;
    svc_next = 1'b0;
    xs_next = 1'b0;
    lost_next = lost_reg;
    if (!standby_pin_n)
    begin
      // pin low wins from any state
      state_next = ST_HW_STANDBY_PIN_N;
      clr_sel = 1'b1;
      lost_next = 1'b1;
    end
    else
    begin
      case (state_reg)
        ST_RESET:
        begin
          // reset rising edge runs the reset sequence
          if (reset_pin_n)
          begin
            state_next = ST_RUN;
            lost_next = 1'b0;
          end
        end
        ST_RUN:
        begin
          if (!reset_pin_n)
          begin
            state_next = ST_RESET;
            clr_sel = 1'b1;
          end
          else if (sleep_exec)
          begin
            // only from execution; select chooses mode
            state_next = sel_bit ? ST_SW_STANDBY_PIN_N : ST_SLEEP;
          end
        end
        ST_SLEEP:
        begin
          if (!reset_pin_n)
          begin
            state_next = ST_RESET;
            clr_sel = 1'b1;
          end
          else if (wake)
          begin
            if (wake_xfer)
            begin
              state_next = ST_XFER;
              xs_next = 1'b1;
            end
            else
            begin
              state_next = ST_RUN;
              svc_next = 1'b1;
            end
          end
        end
        ST_XFER:
        begin
          // reset pin still wins while the transfer runs
          if (!reset_pin_n)
          begin
            state_next = ST_RESET;
            clr_sel = 1'b1;
          end
          // back to run; service the interrupt only if the count ran out
          else if (xfer_done)
          begin
            state_next = ST_RUN;
            svc_next = (transfer_count_reg == 16'h0000);
          end
        end
        ST_SW_STANDBY_PIN_N:
        begin
          if (!reset_pin_n)
          begin
            state_next = ST_RESET;
            clr_sel = 1'b1;
          end
          else if (nmi_req)
          begin
            state_next = ST_NMI_WAIT;
            cnt_next = '0;
          end
        end
        ST_NMI_WAIT:
        begin
          // oscillator settle before resuming on nmi
          if (!reset_pin_n)
          begin
            state_next = ST_RESET;
            clr_sel = 1'b1;
          end
          else if (cnt_reg == CNT_W'(NMI_WAIT_CYC - 1))
          begin
            state_next = ST_RUN;
            svc_next = 1'b1;
            clr_sel = 1'b1;
          end
          else
          begin
            cnt_next = cnt_reg + 1'b1;
          end
        end
        ST_HW_STANDBY_PIN_N:
        begin
          // pin high first, reset held low, then rise
          if (!reset_pin_n)
          begin
            state_next = ST_RESET;
          end
        end
        default:
        begin
          state_next = ST_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= ST_RESET;
      cnt_reg <= '0;
      svc_reg <= 1'b0;
      xs_reg <= 1'b0;
      lost_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      svc_reg <= svc_next;
      xs_reg <= xs_next;
      lost_reg <= lost_next;
    end
  end

  // clock stopped: both standby modes and the oscillator settle after nmi
  function automatic logic halted(input pwr_state_e s);
    halted = s == ST_SW_STANDBY_PIN_N || s == ST_HW_STANDBY_PIN_N || s == ST_NMI_WAIT;
  endfunction

  // mode outputs registered from the next state
  logic clk_next;
  logic cpu_next;
  logic mod_next;
  logic init_next;
  logic hiz_next;
  logic rstc_next;
  always_comb
  begin
    clk_next = !halted(state_next);
    cpu_next = state_next == ST_RUN;
    mod_next = state_next == ST_RUN || state_next == ST_SLEEP || state_next == ST_XFER;
    // modules stay initialised until the settle after nmi has ended
    init_next = halted(state_next) || state_next == ST_RESET;
    hiz_next = state_next == ST_HW_STANDBY_PIN_N;
    rstc_next = state_next == ST_RESET || state_next == ST_HW_STANDBY_PIN_N;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      clk_run <= 1'b1;
      cpu_run <= 1'b0;
      modules_run <= 1'b0;
      modules_init <= 1'b1;
      ports_hiz <= 1'b0;
      cpu_reset <= 1'b1;
      cpu_regs_lost <= 1'b0;
      irq_service <= 1'b0;
      xfer_start <= 1'b0;
    end
    else
    begin
      clk_run <= clk_next;
      cpu_run <= cpu_next;
      modules_run <= mod_next;
      modules_init <= init_next;
      ports_hiz <= hiz_next;
      cpu_reset <= rstc_next;
      cpu_regs_lost <= lost_next;
      irq_service <= svc_next;
      xfer_start <= xs_next;
    end
  end
endmodule

// ---- logic/pwr_pkg.sv ----
// power-down mode controller: shared constants and types
// assumes a 32-bit classic wishbone slave port, byte addressed
package pwr_pkg;
  localparam logic [7:0] ADDR_STANDBY_PIN_N_CTRL = 8'h00;
  localparam logic [7:0] ADDR_WAKE_CTRL = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
  localparam int SEL_BIT_POS = 7;
  localparam logic [7:0] STANDBY_PIN_N_CTRL_RESET = 8'h7F;
  localparam logic [7:0] STANDBY_PIN_N_CTRL_RSVD = 8'h7F;
  localparam int WDT_RUN_POS = 0;
  localparam int LEVEL_W = 3;
  localparam logic [LEVEL_W-1:0] MASK_RESET = 3'h7;
  localparam int NMI_WAIT_NS = 1000;
  localparam int CLK_NS = 25;
  localparam int NMI_WAIT_CYC = (NMI_WAIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 12;
  typedef enum logic [2:0] {
    ST_RESET,
    ST_RUN,
    ST_SLEEP,
    ST_SW_STANDBY_PIN_N,
    ST_NMI_WAIT,
    ST_HW_STANDBY_PIN_N,
    ST_XFER
  } pwr_state_e;
endpackage

// ---- logic/pwr_regs.sv ----
// register file: standby control, wake control, interrupt mask level
// assumes one request at a time from the top, answered one cycle later
`timescale 1ns/10ps
module pwr_regs
  import pwr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  pwr_bus_if.slave bus,
  input wire logic [7:0] status_in,
  input wire logic clr_sel,
  output logic sel_bit,
  output logic wdt_run,
  output logic [LEVEL_W-1:0] mask_level
);
  logic sel_reg, sel_next;
  logic wdt_reg, wdt_next;
  logic [LEVEL_W-1:0] mask_reg, mask_next;
  logic ack_reg, ack_next;
  logic [31:0] rdat_reg, rdat_next;
  logic wr;

  always_comb
  begin
    wr = bus.req && bus.we && !ack_reg && bus.sel[0];
    sel_next = sel_reg;
    wdt_next = wdt_reg;
    mask_next = mask_reg;
    ack_next = bus.req && !ack_reg;
    rdat_next = 32'h00000000;
    if (wr && bus.adr == ADDR_STANDBY_PIN_N_CTRL)
    begin
      // select only sets while the watchdog is stopped
      sel_next = bus.wdat[SEL_BIT_POS] && !wdt_reg;
    end
    else if (wr && bus.adr == ADDR_WAKE_CTRL)
    begin
      wdt_next = bus.wdat[WDT_RUN_POS];
    end
    else if (wr && bus.adr == ADDR_IRQ_MASK)
    begin
      mask_next = bus.wdat[LEVEL_W-1:0];
    end
    if (clr_sel)
    begin
      sel_next = 1'b0;
    end
    if (bus.adr == ADDR_STANDBY_PIN_N_CTRL)
    begin
      rdat_next = {24'h000000, sel_reg, STANDBY_PIN_N_CTRL_RSVD[6:0]};
    end
    else if (bus.adr == ADDR_WAKE_CTRL)
    begin
      rdat_next = {31'h00000000, wdt_reg};
    end
    else if (bus.adr == ADDR_STATUS)
    begin
      rdat_next = {24'h000000, status_in};
    end
    else if (bus.adr == ADDR_IRQ_MASK)
    begin
      rdat_next = {29'h00000000, mask_reg};
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sel_reg <= STANDBY_PIN_N_CTRL_RESET[SEL_BIT_POS];
      wdt_reg <= 1'b0;
      mask_reg <= MASK_RESET;
      ack_reg <= 1'b0;
      rdat_reg <= 32'h00000000;
    end
    else
    begin
      sel_reg <= sel_next;
      wdt_reg <= wdt_next;
      mask_reg <= mask_next;
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
    end
  end

  assign bus.ack = ack_reg;
  assign bus.rdat = rdat_reg;
  assign sel_bit = sel_reg;
  assign wdt_run = wdt_reg;
  assign mask_level = mask_reg;
endmodule

// ---- logic/pwr_wake.sv ----
// wake request qualifier: enable gating and priority against the mask
// assumes interrupt requests are levels held by their sources
`timescale 1ns/10ps
module pwr_wake
  import pwr_pkg::*;
(
  input wire logic [7:0] irq_req,
  input wire logic [7:0] irq_en,
  input wire logic [7:0] irq_xfer,
  input wire logic [LEVEL_W-1:0] mask_level,
  output logic wake,
  output logic wake_xfer
);
  // request index doubles as its priority level, 0 lowest
  always_comb
  begin
    wake = 1'b0;
    wake_xfer = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      // disabled or masked requests stay pending
      if (!wake && irq_req[i] && irq_en[i] && 3'(i) > mask_level)
      begin
        wake = 1'b1;
        wake_xfer = irq_xfer[i];
      end
    end
  end
endmodule

// ---- testbench/pwr_ctrl_monitor.sv ----
// checker for the power-down controller top ports
// assumes it is bound to pwr_ctrl, one clock, rst high active
`timescale 1ns/10ps
module pwr_ctrl_monitor
(
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic sleep_exec,
  input wire logic reset_pin_n,
  input wire logic standby_pin_n,
  input wire logic clk_run,
  input wire logic cpu_run,
  input wire logic cpu_regs_lost,
  input wire logic modules_run,
  input wire logic modules_init,
  input wire logic ports_hiz,
  input wire logic irq_service,
  input wire logic cpu_reset
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sleep_entry_a: assert property (sleep_exec && cpu_run && reset_pin_n && standby_pin_n |=> !cpu_run)
    else $error("cpu kept running");
  sleep_clock_a: assert property (!cpu_run && modules_run |-> clk_run)
    else $error("modules without clock");
  sw_halt_a: assert property (!clk_run && !ports_hiz |-> !modules_run && modules_init && !cpu_regs_lost)
    else $error("standby not halted");
  hw_entry_a: assert property (!standby_pin_n |=> ports_hiz && !clk_run && !cpu_run && cpu_regs_lost)
    else $error("no hardware standby");
  hw_hold_a: assert property (ports_hiz && reset_pin_n |=> ports_hiz)
    else $error("left standby early");
  hw_exit_a: assert property (ports_hiz && standby_pin_n && !reset_pin_n |=> cpu_reset && !ports_hiz)
    else $error("no reset after standby");
  reset_wake_a: assert property (!reset_pin_n && standby_pin_n |=> cpu_reset && !cpu_run)
    else $error("reset pin ignored");
  service_run_a: assert property (irq_service |-> cpu_run && clk_run)
    else $error("service while halted");
  bus_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bad bus answer");
  cover property (irq_service);
  cover property (ports_hiz && !reset_pin_n);
  cover property (sleep_exec && cpu_run);
endmodule

// ---- testbench/pwr_ctrl_tb_top.sv ----
// bench: random and corner scenarios for the power-down controller
// assumes the checker bound below and the transfer model
`timescale 1ns/10ps
module pwr_ctrl_tb_top
  import pwr_pkg::*;
;
  logic clk, rst, cyc, stb, we, slp, rpin_n, spin_n, nmi, xdone, ack;
  logic clk_run, cpu_run, lost, mrun, minit, hiz, svc, xst, crst;
  logic [7:0] adr, ireq, ien, ixfer, r, e, x;
  logic [31:0] wd, rd, dout;
  logic [3:0] sel, dly;
  logic [15:0] cnt, tcnt;
  logic [2:0] m;
  int n_errors = 0;
  int tests_run = 0;
  int n, i, w;
  pwr_ctrl u_pwr_ctrl (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_dat_i(wd), .wb_sel_i(sel), .wb_dat_o(dout), .wb_ack_o(ack), .sleep_exec(slp), .reset_pin_n(rpin_n),
    .standby_pin_n(spin_n), .nmi_req(nmi), .irq_req(ireq), .irq_en(ien), .irq_xfer(ixfer), .xfer_done(xdone),
    .transfer_count_reg(tcnt), .clk_run(clk_run), .cpu_run(cpu_run), .cpu_regs_lost(lost), .modules_run(mrun),
    .modules_init(minit), .ports_hiz(hiz), .irq_service(svc), .xfer_start(xst), .cpu_reset(crst));
  pwr_xfer_model u_pwr_xfer_model (.clk(clk), .rst(rst), .xfer_start(xst), .dly(dly), .cnt(cnt),
    .xfer_done(xdone), .transfer_count_reg(tcnt));
  // 0 no wake, 1 cpu service, 2 transfer; highest level wins
  function automatic int exp_wake(logic [7:0] q, en, xf, logic [2:0] mk);
    exp_wake = 0;
    for (int k = 0; k < 8; k++)
      if (q[k] && en[k] && k > mk)
        exp_wake = xf[k] ? 2 : 1;
  endfunction
  // {clk_run, cpu_run, modules_run, modules_init, ports_hiz}
  function automatic logic [31:0] exp_mode(pwr_state_e s);
    case (s)
      ST_RUN: exp_mode = 32'h1C;
      ST_SLEEP: exp_mode = 32'h14;
      ST_SW_STANDBY_PIN_N: exp_mode = 32'h02;
      ST_HW_STANDBY_PIN_N: exp_mode = 32'h03;
      default: exp_mode = 32'h12;
    endcase
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] x0);
    tests_run++;
    if (g !== x0)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, x0);
    end
  endtask
  task automatic complete_run();
    $display("errors=%0d checks=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk);
    {cyc, stb, we, adr, wd, sel} <= {1'b1, 1'b1, wr, a, d, 4'hF};
    do @(posedge clk); while (ack !== 1'b1 && ++t < 20);
    rd = dout;
    {cyc, stb, we} <= 3'h0;
    chk({31'h0, ack}, 32'h1);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] x0);
    bus(a, 1'b0, 32'h0);
    chk(rd, x0);
  endtask
  task automatic chk_st(input pwr_state_e s);
    chk({27'h0, clk_run, cpu_run, mrun, minit, hiz}, exp_mode(s));
    bus(ADDR_STATUS, 1'b0, 32'h0);
    chk(rd & 32'h7, 32'(s));
  endtask
  task automatic pulse_sleep();
    @(posedge clk);
    slp <= 1'b1;
    @(posedge clk);
    slp <= 1'b0;
    @(posedge clk);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    #(25 * 30000);
    n_errors++;
    complete_run();
  end
  initial
  begin
    {cyc, stb, we, slp, nmi, ireq, ien, ixfer, dly, cnt, adr, wd} = '0;
    {rpin_n, spin_n, rst, sel} = 7'h7F;
    void'($urandom(5));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk_st(ST_RUN);
    rd_chk(ADDR_STANDBY_PIN_N_CTRL, 32'h7F);
    rd_chk(ADDR_IRQ_MASK, 32'h7);
    rd_chk(8'h10, 32'h0);
    bus(ADDR_WAKE_CTRL, 1'b1, 32'h1);
    bus(ADDR_STANDBY_PIN_N_CTRL, 1'b1, 32'h80);
    rd_chk(ADDR_STANDBY_PIN_N_CTRL, 32'h7F);
    bus(ADDR_WAKE_CTRL, 1'b1, 32'h0);
    bus(ADDR_STANDBY_PIN_N_CTRL, 1'b1, 32'h80);
    rd_chk(ADDR_STANDBY_PIN_N_CTRL, 32'hFF);
    pulse_sleep();
    chk_st(ST_SW_STANDBY_PIN_N);
    bus(ADDR_IRQ_MASK, 1'b1, 32'h0);
    {ien, ireq} <= 16'hFF80;
    repeat (4) @(posedge clk);
    chk_st(ST_SW_STANDBY_PIN_N);
    {ireq, nmi} <= 9'h001;
    @(posedge clk);
    nmi <= 1'b0;
    for (n = 0; n < 100 && svc !== 1'b1; n++) @(posedge clk);
    chk(32'(n), 32'(NMI_WAIT_CYC + 1));
    chk_st(ST_RUN);
    rd_chk(ADDR_STANDBY_PIN_N_CTRL, 32'h7F);
    for (i = 0; i < 14; i++)
    begin
      m = i == 0 ? 3'h3 : 3'($urandom);
      r = i == 0 ? 8'h08 : 8'($urandom);
      e = i == 1 ? 8'h00 : 8'($urandom) | {7'h0, i == 0};
      x = 8'($urandom);
      w = exp_wake(r, i == 0 ? 8'hFF : e, x, m);
      bus(ADDR_IRQ_MASK, 1'b1, {29'h0, m});
      pulse_sleep();
      pulse_sleep();
      chk_st(ST_SLEEP);
      {ireq, ien, ixfer} <= {r, i == 0 ? 8'hFF : e, x};
      dly <= 4'($urandom);
      cnt <= i % 3 == 0 ? 16'h0 : 16'($urandom) | 16'h1;
      for (n = 0; n < 8 && svc !== 1'b1 && xst !== 1'b1; n++) @(posedge clk);
      chk({30'h0, xst, svc}, 32'(w));
      {ireq, ien} <= 16'h0;
      if (w == 2)
      begin
        for (n = 0; n < 30 && xdone !== 1'b1; n++) @(posedge clk);
        @(posedge clk);
        chk({31'h0, svc}, {31'h0, cnt == 16'h0});
        chk_st(ST_RUN);
      end
      else if (w == 0)
      begin
        rpin_n <= 1'b0;
        repeat (2) @(posedge clk);
        chk_st(ST_RESET);
        rpin_n <= 1'b1;
        repeat (2) @(posedge clk);
      end
      chk_st(ST_RUN);
    end
    pulse_sleep();
    spin_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk_st(ST_HW_STANDBY_PIN_N);
    rd_chk(ADDR_STATUS, 32'hD);
    spin_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk_st(ST_HW_STANDBY_PIN_N);
    rpin_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk_st(ST_RESET);
    rpin_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd_chk(ADDR_STATUS, 32'h1);
    bus(ADDR_STANDBY_PIN_N_CTRL, 1'b1, 32'h80);
    pulse_sleep();
    spin_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk_st(ST_HW_STANDBY_PIN_N);
    rd_chk(ADDR_STANDBY_PIN_N_CTRL, 32'h7F);
    complete_run();
  end
endmodule
bind pwr_ctrl pwr_ctrl_monitor u_pwr_ctrl_monitor (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .sleep_exec(sleep_exec), .reset_pin_n(reset_pin_n),
  .standby_pin_n(standby_pin_n), .clk_run(clk_run), .cpu_run(cpu_run), .cpu_regs_lost(cpu_regs_lost),
  .modules_run(modules_run), .modules_init(modules_init), .ports_hiz(ports_hiz), .irq_service(irq_service),
  .cpu_reset(cpu_reset));

// ---- testbench/pwr_xfer_model.sv ----
// transfer controller stand-in: ends each transfer after a delay
// assumes dly and cnt held by the bench during a transfer
`timescale 1ns/10ps
module pwr_xfer_model
(
  input wire logic clk,
  input wire logic rst,
  input wire logic xfer_start,
  input wire logic [3:0] dly,
  input wire logic [15:0] cnt,
  output logic xfer_done,
  output logic [15:0] transfer_count_reg
);
  logic [4:0] left_reg;
  // count only valid with done, inverted otherwise
  assign transfer_count_reg = xfer_done ? cnt : ~cnt;
  assign xfer_done = left_reg == 5'h01;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      left_reg <= 5'h00;
    else if (xfer_start)
      left_reg <= {1'b0, dly} + 5'h02;
    else if (left_reg != 5'h00)
      left_reg <= left_reg - 5'h01;
  end
endmodule
